/* File: design/pulse_counter_params.svh */
// ---------------------------------------------------------------------------
// Summary of operation
// - Index rising with index load enable set copies preset into count.
// - Limit switch rising with limit load enable set copies preset.
// - Present index input level is readable as a status bit.
// - Counting scheme field: 0 pulse/direction, 1 up/down, 2 quadrature.
// - Rate window select: 0 gives one second, 1 gives 200 ms.
// - Window total is count at window end minus count at start.
// - Write-only 32-bit preset value, zero after reset.
// - Preset loads only on forced load, enabled index or limit.
// - Writing one to forced load copies preset; zero does nothing.
// - Writing one to freeze holds the count; zero does nothing.
// - Index load enable clear means index never presets the count.
// - Limit load enable clear means limit switch never presets.
// - Two compare outputs on within a range, each readable.
// - A compare output stays off unless programmed and gated on.
// - Write-only gate bit per output enables its points.
// ---------------------------------------------------------------------------
`ifndef PULSE_COUNTER_PARAMS_SVH
`define PULSE_COUNTER_PARAMS_SVH

// ---------------------------------------------------------------------------
// Register offsets (byte addresses on an 8-bit APB address).
// ---------------------------------------------------------------------------
`define OFS_SETUP     8'h00
`define OFS_PRESET    8'h04
`define OFS_COUNT     8'h08
`define OFS_WINDOW    8'h0c
`define OFS_STATUS    8'h10
`define OFS_GATE      8'h14
`define OFS_ON_BASE   8'h18
`define OFS_OFF_BASE  8'h20
`define OFS_STRIDE    8'h04

// ---------------------------------------------------------------------------
// Field positions.
// ---------------------------------------------------------------------------
`define SETUP_SCHEME_LSB   0
`define SETUP_SCHEME_MSB   1
`define SETUP_RATE_BIT     2
`define SETUP_INDEX_BIT    3
`define SETUP_LIMIT_BIT    4
`define SETUP_FORCE_BIT    5
`define SETUP_FREEZE_BIT   6
`define SETUP_RESUME_BIT   7
`define STAT_A_BIT         0
`define STAT_B_BIT         1
`define STAT_INDEX_BIT     2
`define STAT_LIMIT_BIT     3
`define STAT_CMP_LSB       4

// ---------------------------------------------------------------------------
// Reset values and timing.
// ---------------------------------------------------------------------------
`define PRESET_RESET   32'h0000_0000
`define SCHEME_RESET   2'h0
`define CLK_KHZ        25000
`define WIN_LONG_MS    1000
`define WIN_SHORT_MS   200

`endif

/* File: design/pulse_counter_pkg.sv */
package pulse_counter_pkg;

  // Counting schemes in field order; code 3 is illegal.
  typedef enum logic [1:0] {
    SCHEME_PULSE_DIR,
    SCHEME_UP_DOWN,
    SCHEME_QUAD
  } counting_scheme_t;

  // One count step request from the pulse decoder.
  typedef struct packed {
    logic up;
    logic down;
  } count_step_t;

  // Settings of one compare output.
  typedef struct packed {
    logic [31:0] on_point;
    logic [31:0] off_point;
    logic        armed;
  } compare_cfg_t;

endpackage

/* File: design/step_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
module step_decoder (
  input  wire logic                       mclk_i,
  input  wire logic                       rst_n_i,
  input  wire logic [1:0]                 scheme_i,
  input  wire logic                       pulse_a_i,
  input  wire logic                       pulse_b_i,
  output pulse_counter_pkg::count_step_t  step_o
);

  logic a_q;
  logic b_q;
  logic rise_a;
  logic rise_b;
  logic moved;

  // Previous input levels for edge detection.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      a_q <= pulse_a_i;
      b_q <= pulse_b_i;
    end
  end

  assign rise_a = pulse_a_i & ~a_q;
  assign rise_b = pulse_b_i & ~b_q;
  assign moved  = (pulse_a_i ^ a_q) | (pulse_b_i ^ b_q);

  // Quadrature counts every edge; direction comes from old A against new B.
  always_comb begin
    step_o = '0;
    unique case (pulse_counter_pkg::counting_scheme_t'(scheme_i))
      pulse_counter_pkg::SCHEME_PULSE_DIR: begin
        step_o.up   = rise_a & ~pulse_b_i;
        step_o.down = rise_a & pulse_b_i;
      end
      pulse_counter_pkg::SCHEME_UP_DOWN: begin
        step_o.up   = rise_a;
        step_o.down = rise_b;
      end
      pulse_counter_pkg::SCHEME_QUAD: begin
        step_o.up   = moved & ~(a_q ^ pulse_b_i);
        step_o.down = moved & (a_q ^ pulse_b_i);
      end
      default: begin
        step_o = '0;
      end
    endcase
  end

endmodule
`default_nettype wire

/* File: design/compare_unit.sv */
`timescale 1ns/100ps
`default_nettype none
module compare_unit (
  input  wire logic                            mclk_i,
  input  wire logic                            rst_n_i,
  input  wire logic [31:0]                     count_i,
  input  wire pulse_counter_pkg::compare_cfg_t cfg_i,
  output logic                                 on_o
);

  // The point is matched exactly, so a count jumping past it is missed.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_o <= 1'b0;
    end else if (!cfg_i.armed) begin
      on_o <= 1'b0;
    end else if (!on_o && count_i == cfg_i.on_point) begin
      on_o <= 1'b1;
    end else if (on_o && count_i == cfg_i.off_point) begin
      on_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: design/pulse_counter_preset_compare.sv */
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "pulse_counter_params.svh"
module pulse_counter_preset_compare #(
  parameter int unsigned NUM_CMP      = 2,
  parameter int unsigned WIN_LONG_CYC = `WIN_LONG_MS * `CLK_KHZ,
  parameter int unsigned WIN_SHORT_CYC = `WIN_SHORT_MS * `CLK_KHZ
) (
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  input  wire logic [7:0]         paddr_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [31:0]        pwdata_i,
  output logic [31:0]             prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  input  wire logic               pulse_a_i,
  input  wire logic               pulse_b_i,
  input  wire logic               index_i,
  input  wire logic               limit_switch_input_i,
  output logic [NUM_CMP-1:0]      window_compare_output_o
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam int unsigned TW = $clog2(WIN_LONG_CYC + 1);

  logic [1:0]                     counting_scheme;
  logic                           rate_window_select;
  logic                           index_load_enable;
  logic                           limit_load_enable;
  logic                           freeze_counting;
  logic [31:0]                    preset;
  logic [31:0]                    count;
  logic [31:0]                    win_start;
  logic [31:0]                    window_pulse_total;
  logic [TW-1:0]                  win_timer;
  logic [TW-1:0]                  win_len;
  logic                           index_q;
  logic                           limit_q;
  logic                           index_rise;
  logic                           limit_rise;
  logic                           forced_load;
  logic                           do_load;
  logic                           win_restart;
  logic                           wr_en;
  logic                           rd_setup;
  logic                           addr_hit;
  logic [31:0]                    next_rdata;
  logic [NUM_CMP-1:0]             gate;
  logic [NUM_CMP-1:0]             on_written;
  logic [NUM_CMP-1:0]             off_written;
  logic [NUM_CMP-1:0][31:0]       on_point;
  logic [NUM_CMP-1:0][31:0]       off_point;
  logic [NUM_CMP-1:0]             sel_on;
  logic [NUM_CMP-1:0]             sel_off;
  logic [NUM_CMP-1:0]             sig_cmp;
  pulse_counter_pkg::count_step_t step;

  // ----------------------------------------
  // APB strobes
  // ----------------------------------------
  // The slave never waits, so each access phase completes in one cycle.
  assign pready_o  = 1'b1;
  assign wr_en     = psel_i & penable_i & pwrite_i & addr_hit;
  assign rd_setup  = psel_i & ~penable_i & ~pwrite_i;
  assign pslverr_o = psel_i & penable_i & ~addr_hit;

  // Per-output address matches for the point registers.
  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      sel_on[i]  = paddr_i == 8'(`OFS_ON_BASE + `OFS_STRIDE * i);
      sel_off[i] = paddr_i == 8'(`OFS_OFF_BASE + `OFS_STRIDE * i);
    end
  end

  // Any offset outside the map answers with an error.
  always_comb begin
    unique case (paddr_i)
      `OFS_SETUP, `OFS_PRESET, `OFS_COUNT, `OFS_WINDOW,
      `OFS_STATUS, `OFS_GATE: begin
        addr_hit = 1'b1;
      end
      default: begin
        addr_hit = |sel_on | |sel_off;
      end
    endcase
  end

  // ----------------------------------------
  // Setup register
  // ----------------------------------------
  // Scheme and window select are kept; the enables are write-only.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      counting_scheme    <= `SCHEME_RESET;
      rate_window_select <= 1'b0;
      index_load_enable  <= 1'b0;
      limit_load_enable  <= 1'b0;
    end else if (wr_en && paddr_i == `OFS_SETUP) begin
      counting_scheme <=
        pwdata_i[`SETUP_SCHEME_MSB:`SETUP_SCHEME_LSB];
      rate_window_select <= pwdata_i[`SETUP_RATE_BIT];
      index_load_enable  <= pwdata_i[`SETUP_INDEX_BIT];
      limit_load_enable  <= pwdata_i[`SETUP_LIMIT_BIT];
    end
  end

  // Freeze is set by a one in its bit and left alone by a zero; a
  // separate resume bit releases it, and freeze wins if both are set.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      freeze_counting <= 1'b0;
    end else if (wr_en && paddr_i == `OFS_SETUP) begin
      if (pwdata_i[`SETUP_FREEZE_BIT]) begin
        freeze_counting <= 1'b1;
      end else if (pwdata_i[`SETUP_RESUME_BIT]) begin
        freeze_counting <= 1'b0;
      end
    end
  end

  // A forced load lives only in the write cycle itself.
  assign forced_load = wr_en && paddr_i == `OFS_SETUP &&
                       pwdata_i[`SETUP_FORCE_BIT];

  // Preset value, never readable.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      preset <= `PRESET_RESET;
    end else if (wr_en && paddr_i == `OFS_PRESET) begin
      preset <= pwdata_i;
    end
  end

  // ----------------------------------------
  // Index and limit switch edges
  // ----------------------------------------
  // Edges, not levels, so a held switch does not pin the count at preset.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      index_q <= 1'b0;
      limit_q <= 1'b0;
    end else begin
      index_q <= index_i;
      limit_q <= limit_switch_input_i;
    end
  end

  assign index_rise = index_i & ~index_q;
  assign limit_rise = limit_switch_input_i & ~limit_q;

  assign do_load = forced_load |
                   (index_load_enable & index_rise) |
                   (limit_load_enable & limit_rise);

  // ----------------------------------------
  // Pulse counter
  // ----------------------------------------
  step_decoder u_decoder (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .scheme_i  (counting_scheme),
    .pulse_a_i (pulse_a_i),
    .pulse_b_i (pulse_b_i),
    .step_o    (step)
  );

  // A load beats a pulse step and still acts while the count is frozen.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else if (do_load) begin
      count <= preset;
    end else if (!freeze_counting) begin
      if (step.up && !step.down) begin
        count <= count + 32'h0000_0001;
      end else if (step.down && !step.up) begin
        count <= count - 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------
  // Rate window
  // ----------------------------------------
  assign win_len = rate_window_select ? TW'(WIN_SHORT_CYC)
                                      : TW'(WIN_LONG_CYC);

  // Changing the window select starts a fresh window at once.
  assign win_restart = wr_en && paddr_i == `OFS_SETUP &&
                       pwdata_i[`SETUP_RATE_BIT] != rate_window_select;

  // The total wraps like the count, so a load inside the window gives a
  // meaningless difference for that one window only.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      win_timer          <= TW'(WIN_LONG_CYC - 1);
      win_start          <= '0;
      window_pulse_total <= '0;
    end else if (win_restart) begin
      win_timer <= (pwdata_i[`SETUP_RATE_BIT] ? TW'(WIN_SHORT_CYC)
                                               : TW'(WIN_LONG_CYC)) -
                   TW'(1);
      win_start <= count;
    end else if (win_timer == '0) begin
      win_timer          <= win_len - TW'(1);
      win_start          <= count;
      window_pulse_total <= count - win_start;
    end else begin
      win_timer <= win_timer - TW'(1);
    end
  end

  // ----------------------------------------
  // Compare outputs
  // ----------------------------------------
  // The pins come straight from the compare flip-flops, with no gating.
  assign window_compare_output_o = sig_cmp;

  generate
    for (genvar g = 0; g < NUM_CMP; g++) begin : g_cmp
      pulse_counter_pkg::compare_cfg_t cfg;

      // Points and gate bits are write-only and start cleared.
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          on_point[g]    <= '0;
          on_written[g]  <= 1'b0;
        end else if (wr_en && sel_on[g]) begin
          on_point[g]    <= pwdata_i;
          on_written[g]  <= 1'b1;
        end
      end

      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          off_point[g]   <= '0;
          off_written[g] <= 1'b0;
        end else if (wr_en && sel_off[g]) begin
          off_point[g]   <= pwdata_i;
          off_written[g] <= 1'b1;
        end
      end

      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          gate[g] <= 1'b0;
        end else if (wr_en && paddr_i == `OFS_GATE) begin
          gate[g] <= pwdata_i[g];
        end
      end

      // Both points must have been written before the gate means anything.
      assign cfg.on_point  = on_point[g];
      assign cfg.off_point = off_point[g];
      assign cfg.armed     = gate[g] & on_written[g] &
                             off_written[g];

      compare_unit u_cmp (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .count_i (count),
        .cfg_i   (cfg),
        .on_o    (sig_cmp[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Write-only registers and bits read as zero.
  always_comb begin
    next_rdata = '0;
    unique case (paddr_i)
      `OFS_SETUP: begin
        next_rdata[`SETUP_SCHEME_MSB:`SETUP_SCHEME_LSB] =
          counting_scheme;
        next_rdata[`SETUP_RATE_BIT] = rate_window_select;
      end
      `OFS_COUNT: begin
        next_rdata = count;
      end
      `OFS_WINDOW: begin
        next_rdata = window_pulse_total;
      end
      `OFS_STATUS: begin
        next_rdata[`STAT_A_BIT]     = pulse_a_i;
        next_rdata[`STAT_B_BIT]     = pulse_b_i;
        next_rdata[`STAT_INDEX_BIT] = index_i;
        next_rdata[`STAT_LIMIT_BIT] = limit_switch_input_i;
        next_rdata[`STAT_CMP_LSB +: NUM_CMP] = sig_cmp;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // Read data is caught in the setup cycle and stands through access.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= '0;
    end else if (rd_setup) begin
      prdata_o <= next_rdata;
    end
  end

endmodule
`default_nettype wire

/* File: sim/pulse_counter_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checker: mirrors software writes and ties outputs to them.
// ----------------------------------------
module pulse_counter_chk #(
  parameter int unsigned NUM_CMP = 2
) (
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  input  wire logic [7:0]         paddr_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [31:0]        pwdata_i,
  input  wire logic [31:0]        prdata_o,
  input  wire logic               pready_o,
  input  wire logic               pslverr_o,
  input  wire logic               index_i,
  input  wire logic [NUM_CMP-1:0] window_compare_output_o
);
  logic [NUM_CMP-1:0] gate_q;
  logic [NUM_CMP-1:0] on_w;
  logic [NUM_CMP-1:0] off_w;
  logic [2:0]         cfg_q;
  logic               wr_c;
  logic               rd_s;

  // Write commit and read setup, as the bus defines them.
  assign wr_c = psel_i & penable_i & pwrite_i;
  assign rd_s = psel_i & ~penable_i & ~pwrite_i;

  // Shadow of the writable settings; only whole commits are mirrored.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_q <= '0;
      on_w   <= '0;
      off_w  <= '0;
      cfg_q  <= 3'h0;
    end else if (wr_c) begin
      if (paddr_i == 8'h14) gate_q <= pwdata_i[NUM_CMP-1:0];
      if (paddr_i == 8'h00) cfg_q <= pwdata_i[2:0];
      for (int i = 0; i < NUM_CMP; i++) begin
        if (paddr_i == 8'h18 + 8'(4 * i)) on_w[i] <= 1'b1;
        if (paddr_i == 8'h20 + 8'(4 * i)) off_w[i] <= 1'b1;
      end
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  for (genvar g = 0; g < NUM_CMP; g++) begin : g_out
    AST_OFF_UNGATED: assert property (
      !gate_q[g] && !$past(gate_q[g]) |-> !window_compare_output_o[g])
      else $error("compare output on with gate clear");
    AST_OFF_UNSET: assert property (
      !(on_w[g] && off_w[g]) |-> !window_compare_output_o[g])
      else $error("compare output on before both points written");
  end

  AST_PRESET_WO: assert property (
    rd_s && paddr_i == 8'h04 |=> prdata_o == 32'h0)
    else $error("preset read is not zero");
  AST_POINTS_WO: assert property (
    rd_s && paddr_i >= 8'h14 && paddr_i <= 8'h24 |=> prdata_o == 32'h0)
    else $error("write-only point or gate read is not zero");
  AST_SETUP_RB: assert property (
    rd_s && paddr_i == 8'h00 |=> prdata_o[7:0] == {5'h0, cfg_q})
    else $error("setup readback differs from last write");
  AST_STATUS_IDX: assert property (
    rd_s && paddr_i == 8'h10 |=> prdata_o[2] == $past(index_i))
    else $error("status index bit differs from input");
  AST_STATUS_CMP: assert property (
    rd_s && paddr_i == 8'h10
      |=> prdata_o[5:4] == $past(window_compare_output_o))
    else $error("status compare bits differ from outputs");
  AST_BUS_ERR: assert property (
    psel_i && penable_i |-> pslverr_o == (paddr_i[1:0] != 2'h0
      || paddr_i > 8'h24))
    else $error("error response does not match address map");
  AST_NO_WAIT: assert property (psel_i && penable_i |-> pready_o)
    else $error("access phase stretched");

  COV_OUT_ON: cover property ($rose(window_compare_output_o[0]));
  COV_ERR: cover property (psel_i && penable_i && pslverr_o);
  COV_IDX_RD: cover property (rd_s && paddr_i == 8'h10 && index_i);
endmodule
`default_nettype wire

/* File: sim/field_source.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Field side: pulse pair, index and limit switch, driven edge by edge.
// ----------------------------------------
module field_source (
  input  wire logic mclk_i,
  output logic      pulse_a_o,
  output logic      pulse_b_o,
  output logic      index_o,
  output logic      limit_o
);
  logic [1:0] pos;

  // Quiet lines at time zero so nothing counts during reset.
  initial begin
    {pulse_a_o, pulse_b_o, index_o, limit_o} = 4'h0;
    pos = 2'h0;
  end

  // One count step per iteration in the chosen scheme; quadrature moves one
  // Gray position a cycle, the others make a full pulse.
  task automatic step(input int n, input logic up, input logic [1:0] sch);
    for (int k = 0; k < n; k++) begin
      @(posedge mclk_i);
      if (sch == 2'h2) begin
        pos = up ? pos + 2'h1 : pos - 2'h1;
        pulse_a_o <= pos[1] ^ pos[0];
        pulse_b_o <= pos[1];
      end else if (sch == 2'h1) begin
        {pulse_a_o, pulse_b_o} <= {up, ~up};
        @(posedge mclk_i);
        {pulse_a_o, pulse_b_o} <= 2'h0;
      end else begin
        pulse_b_o <= ~up;
        @(posedge mclk_i);
        pulse_a_o <= 1'b1;
        @(posedge mclk_i);
        pulse_a_o <= 1'b0;
      end
    end
    @(posedge mclk_i);
    if (sch != 2'h2) pulse_b_o <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask

  // Sets the index (0) or limit (1) level and lets it settle.
  task automatic trig(input int which, input logic lvl);
    @(posedge mclk_i);
    if (which == 0) index_o <= lvl;
    else limit_o <= lvl;
    repeat (3) @(posedge mclk_i);
  endtask
endmodule
`default_nettype wire

/* File: sim/pulse_counter_preset_compare_test.sv */
`timescale 1ns/100ps
`default_nettype none
module pulse_counter_preset_compare_test;
  localparam int WL = 50;
  localparam int WS = 10;
  logic        mclk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o;
  logic        pslverr_o, pulse_a_i, pulse_b_i, index_i;
  logic        limit_switch_input_i, e, rate, ixen, lmen;
  logic [1:0]  out_w, sch;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, exp_cnt, p, q;
  int          err_total, tests_run, n;

  pulse_counter_preset_compare #(
    .WIN_LONG_CYC (WL),
    .WIN_SHORT_CYC(WS)
  ) pulse_counter_preset_compare_i (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .paddr_i(paddr_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .pulse_a_i(pulse_a_i), .pulse_b_i(pulse_b_i),
    .index_i(index_i), .limit_switch_input_i(limit_switch_input_i),
    .window_compare_output_o(out_w)
  );

  field_source field_source_i (
    .mclk_i(mclk_i), .pulse_a_o(pulse_a_i), .pulse_b_o(pulse_b_i),
    .index_o(index_i), .limit_o(limit_switch_input_i)
  );

  // ----------------------------------------
  // Clock, bus tasks and comparisons.
  // ----------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // One transfer; the answer is taken at the edge that sees pready high.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge mclk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
    @(posedge mclk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_total++;
      $display("BAD %0t no ready", $time);
    end
    q = prdata_o;
    e = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(a, 1'b0, 32'h0);
    chk(q, x);
  endtask

  // Setup word: action bits are resume, freeze, forced load.
  function automatic logic [31:0] cfg(input logic [2:0] act);
    return {24'h0, act, lmen, ixen, rate, sch};
  endfunction

  function automatic logic [31:0] stat(input logic [1:0] o);
    return {26'h0, o, limit_switch_input_i, index_i, pulse_b_i, pulse_a_i};
  endfunction

  task automatic force_to(input logic [31:0] v);
    wr(8'h04, v);
    wr(8'h00, cfg(3'b001));
    exp_cnt = v;
  endtask

  task automatic run(input int k, input logic up);
    field_source_i.step(k, up, sch);
    if (sch != 2'h3) exp_cnt = up ? exp_cnt + 32'(k) : exp_cnt - 32'(k);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // A hang anywhere ends the run as a mismatch; tests need under a thousand.
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end

  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {sch, rate, ixen, lmen} = '0;
    {err_total, tests_run, exp_cnt} = '0;
    rst_n_i = 1'b0;
    void'($urandom(32'hd5b56ecf));
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    for (int a = 5; a < 10; a++) rd(8'(4 * a), 32'h0);
    apb(8'h28, 1'b0, 32'h0);
    chk({31'h0, e}, 32'h1);
    run(3, 1'b1);
    wr(8'h00, cfg(3'b001));
    exp_cnt = 32'h0;
    rd(8'h08, exp_cnt);
    $display("test reset done");
    // Undefined scheme 3 goes first and must leave the count alone.
    for (int s = 0; s < 4; s++) begin
      sch = 2'(s + 3);
      rate = 1'($urandom_range(1, 0));
      wr(8'h00, cfg(3'b000));
      rd(8'h00, {29'h0, rate, sch});
      n = $urandom_range(8, 1);
      run(n, 1'b1);
      run(n / 2, 1'b0);
      rd(8'h08, exp_cnt);
    end
    $display("test schemes done");
    p = $urandom;
    wr(8'h04, p);
    rd(8'h08, exp_cnt);
    wr(8'h00, cfg(3'b000));
    rd(8'h08, exp_cnt);
    wr(8'h00, cfg(3'b001));
    exp_cnt = p;
    rd(8'h08, exp_cnt);
    force_to(32'hffff_ffff);
    run(2, 1'b1);
    rd(8'h08, exp_cnt);
    $display("test preset done");
    for (int w = 0; w < 2; w++) begin
      p = $urandom;
      wr(8'h04, p);
      field_source_i.trig(w, 1'b1);
      field_source_i.trig(w, 1'b0);
      rd(8'h08, exp_cnt);
      if (w == 0) ixen = 1'b1;
      else lmen = 1'b1;
      wr(8'h00, cfg(3'b000));
      field_source_i.trig(w, 1'b1);
      exp_cnt = p;
      rd(8'h10, stat(2'h0));
      run($urandom_range(8, 2), 1'b1);
      rd(8'h08, exp_cnt);
      field_source_i.trig(w, 1'b0);
    end
    $display("test index limit done");
    wr(8'h00, cfg(3'b010));
    field_source_i.step(5, 1'b1, sch);
    rd(8'h08, exp_cnt);
    wr(8'h00, cfg(3'b000));
    field_source_i.step(3, 1'b0, sch);
    rd(8'h08, exp_cnt);
    wr(8'h00, cfg(3'b100));
    run(4, 1'b1);
    rd(8'h08, exp_cnt);
    $display("test freeze done");
    p = $urandom;
    n = $urandom_range(7, 4);
    wr(8'h18, p);
    wr(8'h20, p + 32'(n));
    force_to(p - 32'h2);
    run(4, 1'b1);
    chk({30'h0, out_w}, 32'h0);
    wr(8'h14, 32'h3);
    force_to(p - 32'h2);
    run(1, 1'b1);
    chk({30'h0, out_w}, 32'h0);
    run(2, 1'b1);
    chk({30'h0, out_w}, 32'h1);
    rd(8'h10, stat(2'h1));
    run(n, 1'b1);
    chk({30'h0, out_w}, 32'h0);
    $display("test compare done");
    for (int r = 0; r < 2; r++) begin
      rate = (r == 0);
      wr(8'h00, cfg(3'b000));
      fork
        field_source_i.step(200, 1'b1, sch);
        begin
          repeat (170) @(posedge mclk_i);
          apb(8'h0c, 1'b0, 32'h0);
          chk(q, rate ? 32'(WS) : 32'(WL));
        end
      join
      exp_cnt = exp_cnt + 32'd200;
    end
    rd(8'h08, exp_cnt);
    $display("test window done");
    end_of_test();
  end
endmodule

bind pulse_counter_preset_compare pulse_counter_chk #(
  .NUM_CMP(NUM_CMP)
) chk_i (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .paddr_i(paddr_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .index_i(index_i),
  .window_compare_output_o(window_compare_output_o)
);
`default_nettype wire
